//--- ocs_clock_select.sv
// oscillator mode decode, clock select and power-managed mode control
`timescale 1ns/100ps
`include "ocs_defs.svh"
// Contract
// - eight modes from three-bit configuration field
// - clock output is peripheral clock over four
// - clock output stops in sleep, runs idle
// - external modes: clock in, output, PLL per variant
// - crystal modes use both pins, PLL per variant
// - internal PLL modes derive both clocks
// - internal plain modes share postscaler, no PLL
// - frequency select picks internal clock rate
// - select 00 picks primary source per mode
// - primary idle keeps primary oscillator running
// - secondary modes run from Timer1 oscillator
// - Timer1 oscillator may run when timers need
// - internal modes clock device, slow osc allowed
// - fast osc off when slow osc direct
// - sleep stops every clock not required
// - slow osc runs while watchdog needs it
// - configuration fields fixed until reprogrammed
// - tuning register trims, selects source, enables PLL; only the PLL bit acts here, trim and source bits are just stored and read back
// - switch to internal stops primary, clears status
// - return to primary waits ready, then sets status
module ocs_clock_select #(
  parameter int DIV_W = 16
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [11:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [2:0] OSC_MODE_FIELD,
  input wire logic [2:0] PLL_PRESCALE,
  input wire logic CPU_DIV,
  input wire logic SLEEP_EXEC,
  input wire logic WAKE,
  input wire logic PRIMARY_READY,
  input wire logic WDT_EN,
  input wire logic FAILSAFE_CLOCK_MONITOR_EN,
  input wire logic T1_OSC_NEED,
  output logic [7:0] RDATA,
  output logic DIVIDED_CLOCK_OUTPUT,
  output logic DIVIDED_CLOCK_OE_B,
  output logic PRIMARY_OSC_EN,
  output logic CRYSTAL_DRIVE_EN,
  output logic EXT_CLOCK_IN_EN,
  output logic PLL_EN,
  output logic FAST_OSC_EN,
  output logic SLOW_OSC_EN,
  output logic T1_OSC_EN,
  output logic [1:0] SYS_CLK_SRC,
  output logic [2:0] INT_FREQ,
  output logic INT_FROM_POSTSCALER,
  output logic CPU_CLK_EN,
  output logic PERIPH_CLK_EN,
  output logic [2:0] PM_STATE
);
  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    logic [2:0] cfg_mode;
    logic [2:0] cfg_pre;
    logic cfg_div;
    logic cfg_done;
    logic idle_on_sleep;
    logic [2:0] internal_freq_select;
    logic startup_done_status;
    logic [1:0] system_clock_select;
    logic [7:0] oscillator_tuning;
    ocs_pkg::ocs_pm_t pm;
    ocs_pkg::ocs_sw_t sw;
    logic [DIV_W-1:0] div_cnt;
    logic periph_tick;
    logic [7:0] rdata;
    logic divided_clock_output;
    logic divided_clock_output_oe_b;
    logic pri_en;
    logic xtal_en;
    logic ext_en;
    logic pll_en;
    logic fast_en;
    logic slow_en;
    logic t1_en;
    logic [1:0] src;
    logic int_post;
    logic cpu_en;
    logic per_en;
  } ocs_st_t;
  ocs_st_t r_ff;
  ocs_st_t nxt_r;
  ocs_div_if dv ();
  ocs_clkout_div u_div (
    .CLK(CLK),
    .RST_B(RST_B),
    .dv(dv)
  );
  ocs_pkg::ocs_mode_t mode;
  logic is_ext;
  logic is_xtal;
  logic is_int;
  logic pll_variant;
  logic has_clkout;
  logic sleeping;
  logic idling;
  logic on_int;
  logic on_t1;
  logic [DIV_W-1:0] div_lim;
  // ************************************************
  // mode decode
  // ************************************************
  always_comb begin
    mode = ocs_pkg::ocs_mode_t'(r_ff.cfg_mode);
    is_ext = (mode == ocs_pkg::OCS_EXT_CLK) || (mode == ocs_pkg::OCS_EXT_CLK_PLL);
    is_xtal = (mode == ocs_pkg::OCS_CRYSTAL) || (mode == ocs_pkg::OCS_CRYSTAL_PLL);
    is_int = !is_ext && !is_xtal;
    pll_variant = r_ff.cfg_mode[0] ^ is_int ? 1'b0 : 1'b1;
    // internal codes 2/3 carry the PLL, others use bit 0
    if (is_int) begin
      pll_variant = r_ff.cfg_mode[1];
    end else begin
      pll_variant = r_ff.cfg_mode[0];
    end
    // only the two crystal modes (plain and PLL) and the bare internal modes lack clkout
    has_clkout = is_ext || (is_int && r_ff.cfg_mode[0]);
    sleeping = (r_ff.pm == ocs_pkg::OCS_SLEEP);
    idling = (r_ff.pm == ocs_pkg::OCS_PRIMARY_IDLE_MODE) || (r_ff.pm == ocs_pkg::OCS_INT_IDLE)
      || (r_ff.pm == ocs_pkg::OCS_SECONDARY_IDLE_MODE);
    on_int = (r_ff.sw != ocs_pkg::OCS_SW_PRI);
    on_t1 = (r_ff.pm == ocs_pkg::OCS_SECONDARY_RUN_MODE) || (r_ff.pm == ocs_pkg::OCS_SECONDARY_IDLE_MODE);
    // tick divider stands in for the peripheral clock; slower setting, longer period
    div_lim = DIV_W'(r_ff.internal_freq_select == `OCS_INTERNAL_FREQ_SELECT_8M ? 0
      : (1 << (`OCS_INTERNAL_FREQ_SELECT_8M - r_ff.internal_freq_select)) - 1);
  end
  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    nxt_r = r_ff;
    // configuration latched once after reset release, frozen thereafter
    if (!r_ff.cfg_done) begin
      nxt_r.cfg_mode = OSC_MODE_FIELD;
      nxt_r.cfg_pre = PLL_PRESCALE;
      nxt_r.cfg_div = CPU_DIV;
      nxt_r.cfg_done = 1'b1;
    end
    // register writes
    if (WR && ADDR == `OCS_OSC_CTRL_ADDR) begin
      nxt_r.idle_on_sleep = WDATA[`OCS_IDLE_BIT];
      nxt_r.internal_freq_select = WDATA[`OCS_INTERNAL_FREQ_SELECT_HI:`OCS_INTERNAL_FREQ_SELECT_LO];
      // reserved code is refused; field keeps its old value
      if (WDATA[`OCS_SCS_HI:`OCS_SCS_LO] != `OCS_SCS_RSVD) begin
        nxt_r.system_clock_select = WDATA[`OCS_SCS_HI:`OCS_SCS_LO];
      end
    end
    if (WR && ADDR == `OCS_OSC_TUNE_ADDR) begin
      nxt_r.oscillator_tuning = WDATA;
    end
    // read data one cycle after the strobe, zero otherwise
    nxt_r.rdata = 8'h00;
    if (RD && ADDR == `OCS_OSC_CTRL_ADDR) begin
      nxt_r.rdata = {r_ff.idle_on_sleep, r_ff.internal_freq_select,
        r_ff.startup_done_status, 1'b1, r_ff.system_clock_select};
    end else if (RD && ADDR == `OCS_OSC_TUNE_ADDR) begin
      nxt_r.rdata = r_ff.oscillator_tuning;
    end else if (RD && ADDR == `OCS_STAT_ADDR) begin
      nxt_r.rdata = {2'h0, r_ff.cfg_div, r_ff.cfg_pre[1:0], r_ff.cfg_mode};
    end
    // power-managed mode
    unique case (r_ff.pm)
      ocs_pkg::OCS_PRIMARY_RUN_MODE, ocs_pkg::OCS_INT_RUN, ocs_pkg::OCS_SECONDARY_RUN_MODE: begin
        if (SLEEP_EXEC) begin
          if (r_ff.idle_on_sleep) begin
            nxt_r.pm = (r_ff.pm == ocs_pkg::OCS_PRIMARY_RUN_MODE) ? ocs_pkg::OCS_PRIMARY_IDLE_MODE
              : (r_ff.pm == ocs_pkg::OCS_SECONDARY_RUN_MODE) ? ocs_pkg::OCS_SECONDARY_IDLE_MODE
              : ocs_pkg::OCS_INT_IDLE;
          end else begin
            nxt_r.pm = ocs_pkg::OCS_SLEEP;
          end
        end else begin
          nxt_r.pm = (r_ff.system_clock_select == `OCS_SCS_T1) ? ocs_pkg::OCS_SECONDARY_RUN_MODE
            : on_int ? ocs_pkg::OCS_INT_RUN : ocs_pkg::OCS_PRIMARY_RUN_MODE;
        end
      end
      ocs_pkg::OCS_PRIMARY_IDLE_MODE, ocs_pkg::OCS_INT_IDLE, ocs_pkg::OCS_SECONDARY_IDLE_MODE,
      ocs_pkg::OCS_SLEEP: begin
        if (WAKE) begin
          nxt_r.pm = ocs_pkg::OCS_PRIMARY_RUN_MODE;
        end
      end
      default: nxt_r.pm = ocs_pkg::OCS_PRIMARY_RUN_MODE;
    endcase
    // clock switch between primary and internal block
    unique case (r_ff.sw)
      ocs_pkg::OCS_SW_PRI: begin
        if (r_ff.system_clock_select == `OCS_SCS_INT) begin
          nxt_r.sw = ocs_pkg::OCS_SW_INT;
          nxt_r.startup_done_status = 1'b0;
        end
      end
      ocs_pkg::OCS_SW_INT: begin
        if (r_ff.system_clock_select == `OCS_SCS_PRI) begin
          nxt_r.sw = ocs_pkg::OCS_SW_WAIT;
        end
      end
      ocs_pkg::OCS_SW_WAIT: begin
        if (r_ff.system_clock_select == `OCS_SCS_INT) begin
          nxt_r.sw = ocs_pkg::OCS_SW_INT;
        end else if (PRIMARY_READY) begin
          nxt_r.sw = ocs_pkg::OCS_SW_PRI;
          nxt_r.startup_done_status = 1'b1;
        end
      end
      default: nxt_r.sw = ocs_pkg::OCS_SW_PRI;
    endcase
    // peripheral tick divider
    nxt_r.periph_tick = 1'b0;
    if (r_ff.div_cnt >= div_lim) begin
      nxt_r.div_cnt = '0;
      nxt_r.periph_tick = 1'b1;
    end else begin
      nxt_r.div_cnt = r_ff.div_cnt + DIV_W'(1);
    end
    // clock source enables
    nxt_r.src = on_t1 ? `OCS_SCS_T1 : on_int ? `OCS_SCS_INT : `OCS_SCS_PRI;
    // primary runs in primary run/idle and while waiting for it; never in sleep
    nxt_r.pri_en = !sleeping && (r_ff.sw != ocs_pkg::OCS_SW_INT) && !on_t1;
    nxt_r.xtal_en = nxt_r.pri_en && is_xtal;
    nxt_r.ext_en = nxt_r.pri_en && is_ext;
    // PLL only in PLL variants and only when software asks
    nxt_r.pll_en = nxt_r.pri_en && pll_variant
      && r_ff.oscillator_tuning[`OCS_PLL_BIT];
    // slow osc direct means fast osc stays off
    nxt_r.fast_en = !sleeping && (r_ff.internal_freq_select != `OCS_INTERNAL_FREQ_SELECT_31K)
      && ((on_int && !on_t1) || (is_int && nxt_r.pri_en));
    nxt_r.slow_en = WDT_EN || FAILSAFE_CLOCK_MONITOR_EN || (!sleeping && on_int && !on_t1
      && r_ff.internal_freq_select == `OCS_INTERNAL_FREQ_SELECT_31K);
    nxt_r.t1_en = on_t1 || T1_OSC_NEED;
    nxt_r.int_post = is_int && !pll_variant;
    nxt_r.cpu_en = !sleeping && !idling;
    nxt_r.per_en = !sleeping;
    nxt_r.divided_clock_output = has_clkout && dv.clk_out;
    nxt_r.divided_clock_output_oe_b = !has_clkout;
  end
  assign dv.tick = r_ff.periph_tick;
  assign dv.run = r_ff.per_en && has_clkout;
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      r_ff <= '0;
      r_ff.idle_on_sleep <= 1'b0;
      r_ff.internal_freq_select <= `OCS_INTERNAL_FREQ_SELECT_4M;
      r_ff.startup_done_status <= 1'b1;
      r_ff.divided_clock_output_oe_b <= 1'b1;
      r_ff.pm <= ocs_pkg::OCS_PRIMARY_RUN_MODE;
      r_ff.sw <= ocs_pkg::OCS_SW_PRI;
    end else begin
      r_ff <= nxt_r;
    end
  end
  assign RDATA = r_ff.rdata;
  assign DIVIDED_CLOCK_OUTPUT = r_ff.divided_clock_output;
  assign DIVIDED_CLOCK_OE_B = r_ff.divided_clock_output_oe_b;
  assign PRIMARY_OSC_EN = r_ff.pri_en;
  assign CRYSTAL_DRIVE_EN = r_ff.xtal_en;
  assign EXT_CLOCK_IN_EN = r_ff.ext_en;
  assign PLL_EN = r_ff.pll_en;
  assign FAST_OSC_EN = r_ff.fast_en;
  assign SLOW_OSC_EN = r_ff.slow_en;
  assign T1_OSC_EN = r_ff.t1_en;
  assign SYS_CLK_SRC = r_ff.src;
  assign INT_FREQ = r_ff.internal_freq_select;
  assign INT_FROM_POSTSCALER = r_ff.int_post;
  assign CPU_CLK_EN = r_ff.cpu_en;
  assign PERIPH_CLK_EN = r_ff.per_en;
  assign PM_STATE = r_ff.pm;
endmodule

//--- ocs_defs.svh
// constants for the oscillator mode and clock select block
`ifndef OCS_DEFS_SVH
`define OCS_DEFS_SVH
`define OCS_OSC_CTRL_ADDR 12'hFD3
`define OCS_OSC_TUNE_ADDR 12'hF9B
`define OCS_STAT_ADDR 12'hF9C
`define OCS_CTRL_RESET 8'h64
`define OCS_TUNE_RESET 8'h00
`define OCS_IDLE_BIT 7
`define OCS_INTERNAL_FREQ_SELECT_HI 6
`define OCS_INTERNAL_FREQ_SELECT_LO 4
`define OCS_STARTUP_DONE_STATUS_BIT 3
`define OCS_UNIMP_BIT 2
`define OCS_SCS_HI 1
`define OCS_SCS_LO 0
`define OCS_SRC_BIT 7
`define OCS_PLL_BIT 6
`define OCS_TRIM_HI 5
`define OCS_INTERNAL_FREQ_SELECT_8M 3'h7
`define OCS_INTERNAL_FREQ_SELECT_4M 3'h6
`define OCS_INTERNAL_FREQ_SELECT_31K 3'h0
`define OCS_SCS_PRI 2'h0
`define OCS_SCS_T1 2'h1
`define OCS_SCS_RSVD 2'h2
`define OCS_SCS_INT 2'h3
`define OCS_DIVIDED_CLOCK_OUTPUT_DIV 2'h3
`define OCS_FAST_HZ 8000000
`define OCS_SYS_HZ 125000000
`endif

//--- ocs_pkg.sv
// types for the oscillator mode and clock select block
package ocs_pkg;
  typedef enum logic [2:0] {
    OCS_INT_PLAIN = 3'h0,
    OCS_INT_CLKOUT = 3'h1,
    OCS_INT_PLL = 3'h2,
    OCS_INT_PLL_CLKOUT = 3'h3,
    OCS_CRYSTAL = 3'h4,
    OCS_CRYSTAL_PLL = 3'h5,
    OCS_EXT_CLK = 3'h6,
    OCS_EXT_CLK_PLL = 3'h7
  } ocs_mode_t;
  typedef enum logic [2:0] {
    OCS_PRIMARY_RUN_MODE = 3'h0,
    OCS_PRIMARY_IDLE_MODE = 3'h1,
    OCS_INT_RUN = 3'h3,
    OCS_INT_IDLE = 3'h2,
    OCS_SECONDARY_RUN_MODE = 3'h6,
    OCS_SECONDARY_IDLE_MODE = 3'h7,
    OCS_SLEEP = 3'h5
  } ocs_pm_t;
  typedef enum logic [1:0] {
    OCS_SW_PRI = 2'h0,
    OCS_SW_WAIT = 2'h1,
    OCS_SW_INT = 2'h3
  } ocs_sw_t;
endpackage

//--- ocs_div_if.sv
// link between the main block and the clock-out divider
`timescale 1ns/100ps
interface ocs_div_if;
  logic tick;
  logic run;
  logic clk_out;
  modport ctrl (output tick, output run, input clk_out);
  modport div (input tick, input run, output clk_out);
endinterface

//--- ocs_clkout_div.sv
// divide-by-four clock output generator
`timescale 1ns/100ps
`include "ocs_defs.svh"
module ocs_clkout_div (
  input wire logic CLK,
  input wire logic RST_B,
  ocs_div_if.div dv
);
  typedef struct packed {
    logic [1:0] cnt;
    logic out;
  } ocs_div_st_t;
  ocs_div_st_t r_ff;
  ocs_div_st_t nxt_r;
  always_comb begin
    nxt_r = r_ff;
    if (dv.run && dv.tick) begin
      nxt_r.cnt = r_ff.cnt + 2'h1;
      // toggle every two ticks gives one quarter of the tick rate
      if (r_ff.cnt[0]) begin
        nxt_r.out = ~r_ff.out;
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end
  assign dv.clk_out = r_ff.out;
endmodule

//--- ocs_clock_select_monitor.sv
// assertion checker for the clock select block
`timescale 1ns/100ps
`include "ocs_defs.svh"
module ocs_clock_select_monitor (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [11:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic [2:0] OSC_MODE_FIELD,
  input wire logic SLEEP_EXEC,
  input wire logic PRIMARY_READY,
  input wire logic DIVIDED_CLOCK_OUTPUT,
  input wire logic DIVIDED_CLOCK_OE_B,
  input wire logic PRIMARY_OSC_EN,
  input wire logic PLL_EN,
  input wire logic [1:0] SYS_CLK_SRC,
  input wire logic [2:0] PM_STATE
);
  logic [1:0] age_ff;
  logic [2:0] mode_ff;
  logic idle_ff;
  // mirror of the idle bit, since it is not visible at the pins
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      age_ff <= 2'h0;
      idle_ff <= 1'b0;
      mode_ff <= 3'h0;
    end else begin
      age_ff <= (age_ff == 2'h3) ? age_ff : age_ff + 2'h1;
      mode_ff <= (age_ff == 2'h0) ? OSC_MODE_FIELD : mode_ff;
      idle_ff <= (WR && ADDR == `OCS_OSC_CTRL_ADDR) ? WDATA[`OCS_IDLE_BIT] : idle_ff;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  sequence run_sleep;
    SLEEP_EXEC && PM_STATE == ocs_pkg::OCS_PRIMARY_RUN_MODE;
  endsequence
  sequence back_to_pri;
    SYS_CLK_SRC == 2'h3 ##1 SYS_CLK_SRC == 2'h0;
  endsequence
  AST_SLEEP_ENTRY: assert property (
    run_sleep ##0 !idle_ff |=> PM_STATE == ocs_pkg::OCS_SLEEP) else $error("no sleep");
  AST_IDLE_ENTRY: assert property (
    run_sleep ##0 idle_ff |=> PM_STATE == ocs_pkg::OCS_PRIMARY_IDLE_MODE) else $error("no idle");
  AST_SLEEP_STILL: assert property (
    (PM_STATE == ocs_pkg::OCS_SLEEP) [*4] |-> $stable(DIVIDED_CLOCK_OUTPUT))
    else $error("clock out runs in sleep");
  AST_IDLE_TOGGLE: assert property (
    PM_STATE == ocs_pkg::OCS_PRIMARY_IDLE_MODE && !DIVIDED_CLOCK_OE_B |-> ##[1:300]
    ($changed(DIVIDED_CLOCK_OUTPUT) || PM_STATE != ocs_pkg::OCS_PRIMARY_IDLE_MODE))
    else $error("clock out stuck in idle");
  AST_NO_RSVD: assert property (SYS_CLK_SRC != `OCS_SCS_RSVD)
    else $error("reserved source");
  AST_TO_INT: assert property (
    WR && ADDR == `OCS_OSC_CTRL_ADDR && WDATA[1:0] == 2'h3 && PM_STATE == ocs_pkg::OCS_PRIMARY_RUN_MODE
    |-> ##[1:3] (SYS_CLK_SRC == 2'h3 && !PRIMARY_OSC_EN)) else $error("no switch");
  AST_WAIT_READY: assert property (
    back_to_pri |-> $past(PRIMARY_READY) || $past(PRIMARY_READY, 2))
    else $error("switch before ready");
  AST_PLL_VARIANT: assert property (
    PLL_EN && age_ff != 2'h0 |-> mode_ff inside {3'h2, 3'h3, 3'h5, 3'h7})
    else $error("pll in plain mode");
endmodule

//--- ocs_osc_model.sv
// primary oscillator start-up model
`timescale 1ns/100ps
module ocs_osc_model (
  input wire logic clk,
  input wire logic osc_en,
  input wire logic [7:0] start_dly,
  output logic ready
);
  logic [7:0] cnt_ff;
  always_ff @(posedge clk) begin
    if (!osc_en) begin
      cnt_ff <= 8'h00;
    end else if (cnt_ff != start_dly) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
  // a stopped oscillator never reports ready
  assign ready = osc_en && cnt_ff == start_dly;
endmodule

//--- ocs_clock_select_tb.sv
// self-checking bench for the clock select block
`timescale 1ns/100ps
`include "ocs_defs.svh"
module ocs_clock_select_tb;
  localparam logic [11:0] CTL = `OCS_OSC_CTRL_ADDR;
  localparam logic [11:0] TUN = `OCS_OSC_TUNE_ADDR;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [2:0] mode = 3'h0;
  logic slp = 1'b0;
  logic wake = 1'b0;
  logic wdt = 1'b0;
  logic t1n = 1'b0;
  logic [7:0] dly = 8'h01;
  logic rdy, co, oe_b, pri, xtal, ext, pll, fast, slow, t1, post, hold, cpu, per;
  logic [7:0] rdata;
  logic [1:0] src;
  logic [2:0] ifreq;
  logic [2:0] pm;
  int bad_count = 0;
  int num_checks = 0;
  always #4 clk = ~clk;
  ocs_osc_model u_osc (.clk(clk), .osc_en(pri), .start_dly(dly), .ready(rdy));
  ocs_clock_select dut (.CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .OSC_MODE_FIELD(mode), .PLL_PRESCALE(3'h0), .CPU_DIV(1'b0), .SLEEP_EXEC(slp),
    .WAKE(wake), .PRIMARY_READY(rdy), .WDT_EN(wdt), .FAILSAFE_CLOCK_MONITOR_EN(1'b0), .T1_OSC_NEED(t1n),
    .RDATA(rdata), .DIVIDED_CLOCK_OUTPUT(co), .DIVIDED_CLOCK_OE_B(oe_b), .PRIMARY_OSC_EN(pri),
    .CRYSTAL_DRIVE_EN(xtal), .EXT_CLOCK_IN_EN(ext), .PLL_EN(pll), .FAST_OSC_EN(fast),
    .SLOW_OSC_EN(slow), .T1_OSC_EN(t1), .SYS_CLK_SRC(src), .INT_FREQ(ifreq),
    .INT_FROM_POSTSCALER(post), .CPU_CLK_EN(cpu), .PERIPH_CLK_EN(per), .PM_STATE(pm));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("read data", e & m, rdata & m);
  endtask
  task automatic pm_op(input logic up);
    @(posedge clk);
    wake <= up;
    slp <= !up;
    @(posedge clk);
    wake <= 1'b0;
    slp <= 1'b0;
  endtask
  task automatic boot(input logic [2:0] m);
    @(posedge clk);
    rst_b <= 1'b0;
    mode <= m;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask
  // early passes let a rate change settle, the last one times a half period
  task automatic half(input int e);
    logic v;
    int n;
    for (int k = 0; k < 3; k++) begin
      v = co;
      n = 0;
      while (co === v && n < 300) begin
        cyc(1);
        n++;
      end
    end
    chk("clock out half period", 8'(e), 8'(n));
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    for (int m = 0; m < 8; m++) begin
      boot(3'(m));
      rd_reg(CTL, `OCS_CTRL_RESET, 8'hF7);
      rd_reg(TUN, `OCS_TUNE_RESET, 8'hFF);
      rd_reg(12'h000, 8'h00, 8'hFF);
      rd_reg(`OCS_STAT_ADDR, 8'(m), 8'hFF);
      wr_reg(TUN, 8'h40);
      cyc(3);
      chk("output enable", 8'(!(m inside {1, 3, 6, 7})), 8'(oe_b));
      chk("external input", 8'(m >= 6), 8'(ext));
      chk("crystal drive", 8'(m inside {4, 5}), 8'(xtal));
      chk("pll enable", 8'(m inside {2, 3, 5, 7}), 8'(pll));
      chk("postscaler primary", 8'(m < 2), 8'(post));
      mode <= ~mode;
      cyc(3);
      chk("output enable kept", 8'(!(m inside {1, 3, 6, 7})), 8'(oe_b));
    end
    boot(3'h6);
    wdt <= 1'b1;
    for (int f = 0; f < 8; f++) begin
      wr_reg(CTL, {1'b0, 3'(f), 4'h0});
      rd_reg(CTL, {1'b0, 3'(f), 4'h4}, 8'hF7);
      chk("internal frequency", 8'(f), 8'(ifreq));
    end
    half(2);
    wr_reg(CTL, 8'h50);
    half(8);
    wr_reg(CTL, 8'h72);
    rd_reg(CTL, 8'h74, 8'hF7);
    wr_reg(CTL, 8'hF0);
    pm_op(1'b0);
    cyc(1);
    chk("power state", 8'(ocs_pkg::OCS_PRIMARY_IDLE_MODE), 8'(pm));
    chk("primary running", 8'h01, 8'(pri));
    chk("cpu clock", 8'h00, 8'(cpu));
    chk("peripheral clock", 8'h01, 8'(per));
    half(2);
    pm_op(1'b1);
    wr_reg(CTL, 8'h70);
    t1n <= 1'b1;
    pm_op(1'b0);
    cyc(3);
    chk("power state", 8'(ocs_pkg::OCS_SLEEP), 8'(pm));
    chk("primary stopped", 8'h00, 8'(pri));
    chk("slow osc kept", 8'h01, 8'(slow));
    chk("timer1 osc kept", 8'h01, 8'(t1));
    chk("cpu clock", 8'h00, 8'(cpu));
    chk("peripheral clock", 8'h00, 8'(per));
    hold = co;
    cyc(40);
    chk("clock out frozen", 8'(hold), 8'(co));
    t1n <= 1'b0;
    pm_op(1'b1);
    wr_reg(CTL, 8'h71);
    cyc(3);
    chk("clock source", 8'h01, 8'(src));
    chk("power state", 8'(ocs_pkg::OCS_SECONDARY_RUN_MODE), 8'(pm));
    chk("timer1 osc", 8'h01, 8'(t1));
    chk("cpu clock", 8'h01, 8'(cpu));
    // second pass uses a slow oscillator to expose an early switch
    for (int k = 0; k < 2; k++) begin
      dly <= k ? 8'h28 : 8'h01;
      wr_reg(CTL, 8'h73);
      cyc(3);
      chk("clock source", 8'h03, 8'(src));
      chk("primary stopped", 8'h00, 8'(pri));
      chk("fast osc", 8'h01, 8'(fast));
      rd_reg(CTL, 8'h77, 8'hFF);
      wr_reg(CTL, 8'h70);
      cyc(6);
      if (k == 1) begin
        chk("still internal", 8'h03, 8'(src));
      end
      cyc(60);
      chk("clock source", 8'h00, 8'(src));
      rd_reg(CTL, 8'h7C, 8'hFF);
    end
    print_verdict();
  end
endmodule
bind ocs_clock_select ocs_clock_select_monitor u_mon (.CLK, .RST_B, .ADDR, .WDATA, .WR,
  .OSC_MODE_FIELD, .SLEEP_EXEC, .PRIMARY_READY, .DIVIDED_CLOCK_OUTPUT, .DIVIDED_CLOCK_OE_B,
  .PRIMARY_OSC_EN, .PLL_EN, .SYS_CLK_SRC, .PM_STATE);
